// File: dv/tb.sv
// self-checking apb testbench for the call/clear/decrement execution block
`timescale 1ns/10ps
module tb;
   // ----------------------------------------------------------------
   // signals and bench state
   // ----------------------------------------------------------------
   typedef struct {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] m;
      logic        err;
   } ccd_exp_t;

   logic                pclk    = 1'b0;
   logic                presetn = 1'b0;
   logic                psel    = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite  = 1'b0;
   logic [7:0]          paddr   = 8'h00;
   logic [31:0]         pwdata  = 32'h0000_0000;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   ccd_exp_t            exp_q[$];
   int                  errors      = 0;
   int                  check_count = 0;
   logic                z           = 1'b0;
   logic [7:0]          acc         = 8'h00;
   logic [7:0]          vals [3]    = '{8'h01, 8'h00, 8'hff};

   initial begin
      forever #10 pclk = ~pclk;
   end

   ccd_exec u_ccd_exec (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   // ----------------------------------------------------------------
   // verdict and bus tasks
   // ----------------------------------------------------------------
   task automatic finish_test;
      if (errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // one transfer, then one idle edge so a call always gets its gap
   task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] ed, input logic [31:0] m, input logic err);
      int n;
      n = 0;
      exp_q.push_back('{a, ed, m, err});
      psel    <= 1'b1;
      pwrite  <= is_wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         $display("wrong value pready expected 1 seen %b", pready);
         finish_test();
      end
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000, e, 32'hffff_ffff, 1'b0);
   endtask

   task automatic rd_st;
      rd(ccd_pkg::OFS_STATUS, {29'h0000_0003, z});
   endtask

   task automatic cmd(input ccd_pkg::ccd_op_t op, input logic d, input logic [6:0] f,
                      input logic [10:0] k);
      wr(ccd_pkg::OFS_CMD, {5'h00, k, 5'h00, f, d, op});
   endtask

   function automatic logic [7:0] file_a(input logic [6:0] f);
      return ccd_pkg::OFS_FILE | {1'b0, f};
   endfunction

   // forces the null flag low through a decrement of three
   task automatic zclr;
      wr(file_a(7'h7f), 32'h0000_0003);
      cmd(ccd_pkg::CCD_OP_REG_DEC, 1'b1, 7'h7f, 11'h000);
      z = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // answer monitor
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      if (presetn === 1'b1 && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("wrong value answer expected none seen %h", prdata);
         end else begin
            ccd_exp_t e;
            e = exp_q.pop_front();
            check_count++;
            if ((prdata & e.m) !== (e.d & e.m) || pslverr !== e.err) begin
               errors++;
               $display("wrong value addr %h expected %h/%b seen %h/%b",
                        e.a, e.d & e.m, e.err, prdata & e.m, pslverr);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0]  v;
      logic [7:0]  res;
      logic [6:0]  f;
      logic [6:0]  l;
      logic [14:0] p;
      logic [10:0] k;
      logic        d;
      int          r;
      ccd_pkg::ccd_op_t op;
      r = $urandom(32'h3809);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(ccd_pkg::OFS_PC, 32'h0000_0000);
      rd(ccd_pkg::OFS_ACC, 32'h0000_0000);
      rd(ccd_pkg::OFS_LATCH, 32'h0000_0000);
      rd_st();
      // boundary operands first, then a random one, both destinations
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 4; j++) begin
            v   = (i == 3) ? 8'($urandom) : vals[i];
            f   = 7'($urandom);
            d   = j[0];
            op  = j[1] ? ccd_pkg::CCD_OP_REG_INV : ccd_pkg::CCD_OP_REG_DEC;
            res = j[1] ? ~v : v - 8'h01;
            wr(file_a(f), {24'h000000, v});
            cmd(op, d, f, 11'h000);
            z = (res == 8'h00);
            if (d == 1'b0) acc = res;
            rd(file_a(f), {24'h000000, d ? res : v});
            rd(ccd_pkg::OFS_ACC, {24'h000000, acc});
            rd_st();
         end
      end
      zclr();
      f = 7'($urandom);
      wr(file_a(f), 32'h0000_00a5);
      cmd(ccd_pkg::CCD_OP_REG_ZERO, 1'b0, f, 11'h000);
      z = 1'b1;
      rd(file_a(f), 32'h0000_0000);
      rd_st();
      zclr();
      wr(ccd_pkg::OFS_ACC, 32'h0000_005c);
      cmd(ccd_pkg::CCD_OP_ACC_ZERO, 1'b0, 7'h00, 11'h000);
      z = 1'b1;
      rd(ccd_pkg::OFS_ACC, 32'h0000_0000);
      rd_st();
      cmd(ccd_pkg::CCD_OP_TIMER_CLR, 1'b0, 7'h00, 11'h000);
      xfer(1'b0, ccd_pkg::OFS_TIMER, 32'h0, 32'h0, 32'hffff_80ff, 1'b0);
      rd_st();
      // immediate call with the null flag high
      l = 7'($urandom);
      p = 15'($urandom);
      k = 11'($urandom);
      wr(ccd_pkg::OFS_LATCH, {25'h0, l});
      wr(ccd_pkg::OFS_PC, {17'h0, p});
      cmd(ccd_pkg::CCD_OP_CALL_IMM, 1'b0, 7'h00, k);
      rd(ccd_pkg::OFS_PC, {17'h0, l[6:3], k});
      rd(ccd_pkg::OFS_STACK, {17'h0, p + 15'h0001});
      rd_st();
      // accumulator call, then a nested immediate call
      zclr();
      v = 8'($urandom);
      l = 7'($urandom);
      p = 15'($urandom);
      wr(ccd_pkg::OFS_ACC, {24'h000000, v});
      wr(ccd_pkg::OFS_LATCH, {25'h0, l});
      wr(ccd_pkg::OFS_PC, {17'h0, p});
      cmd(ccd_pkg::CCD_OP_NONE, 1'b0, 7'h00, 11'h000);
      rd(ccd_pkg::OFS_PC, {17'h0, p});
      cmd(ccd_pkg::CCD_OP_CALL_ACC, 1'b0, 7'h00, 11'h000);
      rd(ccd_pkg::OFS_PC, {17'h0, l, v});
      rd(ccd_pkg::OFS_STACK, {17'h0, p + 15'h0001});
      rd_st();
      k = 11'($urandom);
      cmd(ccd_pkg::CCD_OP_CALL_IMM, 1'b0, 7'h00, k);
      rd(ccd_pkg::OFS_STACK, {17'h0, {l, v} + 15'h0001});
      wr(ccd_pkg::OFS_STACK, 32'h0000_0000);
      rd(ccd_pkg::OFS_STACK, {17'h0, {l, v} + 15'h0001});
      rd(ccd_pkg::OFS_PC, {17'h0, l[6:3], k});
      // unmapped places answer with an error
      xfer(1'b0, 8'h40, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
      xfer(1'b1, 8'h1c, 32'h1234_5678, 32'h0, 32'h0, 1'b1);
      rd_st();
      repeat (3) @(posedge pclk);
      if (exp_q.size() != 0) begin
         errors++;
         $display("wrong value answers pending expected 0 seen %0d", exp_q.size());
      end
      finish_test();
   end
endmodule // tb

// File: hw/ccd_exec.sv
// execution unit for calls, clears, invert and decrement, apb reachable
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ccd_exec #(
   parameter int STK_DEPTH = ccd_pkg::STK_DEPTH
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_EXEC2} ccd_state_t;
   ccd_state_t   state_q;
   logic [14:0]  pc_q;
   logic [7:0]   acc_q;
   logic [6:0]   upper_pc_latch_q;
   logic [14:0]  stack_q [STK_DEPTH];
   logic [3:0]   sp_q;
   logic [7:0]   supervisory_timer_q;
   logic [7:0]   timer_pre_q;
   logic         zero_flag_q;
   logic         dog_expiry_flag_q;
   logic         sleep_entered_flag_q;
   logic [31:0]  prdata_q;
   logic         pready_q;
   logic         pslverr_q;
   logic [7:0]   fr_rdata;
   logic [6:0]   fr_raddr;
   logic         fr_we;
   logic [6:0]   fr_waddr;
   logic [7:0]   fr_wdata;

   wire          acc_cyc  = psel && penable && !pready_q;
   wire          wr_cyc   = acc_cyc && pwrite;
   wire          cmd_wr   = wr_cyc && paddr == ccd_pkg::OFS_CMD && state_q == ST_IDLE;
   wire          file_hit = paddr[7];
   wire [2:0]    op_raw   = pwdata[ccd_pkg::CMD_OP_LSB +: 3];
   wire          dest_reg = pwdata[ccd_pkg::CMD_D_BIT];
   wire [6:0]    f_addr   = pwdata[ccd_pkg::CMD_F_LSB +: 7];
   wire [10:0]   k_imm    = pwdata[ccd_pkg::CMD_K_LSB +: 11];
   wire [14:0]   pc_inc   = pc_q + 15'h0001;

   function automatic logic [14:0] call_target(input logic acc_form, input logic [10:0] k,
                                              input logic [7:0] acc, input logic [6:0] lat);
      if (acc_form) call_target = {lat, acc};
      else          call_target = {lat[6:3], k};
   endfunction

   // ----------------------------------------------------------------
   // file register port: commands read f, software reads its offset
   // ----------------------------------------------------------------
   assign fr_raddr = (cmd_wr) ? f_addr : paddr[6:0];

   always_comb begin
      fr_we    = 1'b0;
      fr_waddr = f_addr;
      fr_wdata = 8'h00;
      if (cmd_wr) begin
         unique case (ccd_pkg::ccd_op_t'(op_raw))
            ccd_pkg::CCD_OP_REG_ZERO: begin
               fr_we = 1'b1;
            end
            ccd_pkg::CCD_OP_REG_INV: begin
               fr_we    = dest_reg;
               fr_wdata = ~fr_rdata;
            end
            ccd_pkg::CCD_OP_REG_DEC: begin
               fr_we    = dest_reg;
               fr_wdata = fr_rdata - 8'h01;
            end
            default: ;
         endcase
      end else if (wr_cyc && file_hit) begin
         fr_we    = 1'b1;
         fr_waddr = paddr[6:0];
         fr_wdata = pwdata[7:0];
      end
   end

   ccd_file_ram #(.AW(ccd_pkg::FADDR_W)) u_file (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (fr_we),
      .waddr   (fr_waddr),
      .wdata   (fr_wdata),
      .raddr   (fr_raddr),
      .rdata   (fr_rdata)
   );

   // ----------------------------------------------------------------
   // sequencing: calls occupy two cycles, second cycle loads pc
   // ----------------------------------------------------------------
   logic         call_acc_q;
   logic [10:0]  k_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= ST_IDLE;
         call_acc_q <= 1'b0;
         k_q        <= 11'h000;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (cmd_wr && (op_raw == 3'(ccd_pkg::CCD_OP_CALL_IMM) ||
                              op_raw == 3'(ccd_pkg::CCD_OP_CALL_ACC))) begin
                  state_q    <= ST_EXEC2;
                  call_acc_q <= op_raw == 3'(ccd_pkg::CCD_OP_CALL_ACC);
                  k_q        <= k_imm;
               end
            end
            ST_EXEC2: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // program counter and stack
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= ccd_pkg::PC_RST;
      end else if (state_q == ST_EXEC2) begin
         pc_q <= call_target(call_acc_q, k_q, acc_q, upper_pc_latch_q);
      end else if (wr_cyc && paddr == ccd_pkg::OFS_PC) begin
         pc_q <= pwdata[14:0];
      end else if (cmd_wr && op_raw != 3'(ccd_pkg::CCD_OP_NONE)) begin
         pc_q <= pc_inc;
      end
   end

   // stack wraps silently when full, matching a circular hardware stack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_q <= '1;
         for (int i = 0; i < STK_DEPTH; i++) stack_q[i] <= ccd_pkg::PC_RST;
      end else if (cmd_wr && (op_raw == 3'(ccd_pkg::CCD_OP_CALL_IMM) ||
                              op_raw == 3'(ccd_pkg::CCD_OP_CALL_ACC))) begin
         sp_q                 <= sp_q + 4'h1;
         stack_q[sp_q + 4'h1] <= pc_inc;
      end
   end

   // ----------------------------------------------------------------
   // accumulator, latch, status flags
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= ccd_pkg::ACC_RST;
      end else if (cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_ACC_ZERO)) begin
         acc_q <= 8'h00;
      end else if (cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_REG_INV) && !dest_reg) begin
         acc_q <= ~fr_rdata;
      end else if (cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_REG_DEC) && !dest_reg) begin
         acc_q <= fr_rdata - 8'h01;
      end else if (wr_cyc && paddr == ccd_pkg::OFS_ACC) begin
         acc_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_pc_latch_q <= 7'h00;
      end else if (wr_cyc && paddr == ccd_pkg::OFS_LATCH) begin
         upper_pc_latch_q <= pwdata[6:0];
      end
   end

   // calls match no branch here, so flags hold through them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_flag_q <= 1'b0;
      end else if (cmd_wr) begin
         unique case (ccd_pkg::ccd_op_t'(op_raw))
            ccd_pkg::CCD_OP_REG_ZERO, ccd_pkg::CCD_OP_ACC_ZERO:
               zero_flag_q <= 1'b1;
            ccd_pkg::CCD_OP_REG_INV:
               zero_flag_q <= (~fr_rdata) == 8'h00;
            ccd_pkg::CCD_OP_REG_DEC:
               zero_flag_q <= fr_rdata == 8'h01;
            default: ;
         endcase
      end
   end

   // timer free-runs as a stand-in count so the clear is observable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supervisory_timer_q  <= ccd_pkg::TIMER_CLR_V;
         timer_pre_q          <= ccd_pkg::TIMER_CLR_V;
         dog_expiry_flag_q    <= 1'b1;
         sleep_entered_flag_q <= 1'b1;
      end else if (cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_TIMER_CLR)) begin
         supervisory_timer_q  <= ccd_pkg::TIMER_CLR_V;
         timer_pre_q          <= ccd_pkg::TIMER_CLR_V;
         dog_expiry_flag_q    <= 1'b1;
         sleep_entered_flag_q <= 1'b1;
      end else begin
         timer_pre_q <= timer_pre_q + 8'h01;
         if (timer_pre_q == 8'hff) supervisory_timer_q <= supervisory_timer_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // apb slave: one wait state, unmapped reads zero with error
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   logic        hit;
   always_comb begin
      rd_mux = 32'h0000_0000;
      hit    = 1'b1;
      if (file_hit) rd_mux = {24'h000000, fr_rdata};
      else begin
         unique case (paddr)
            ccd_pkg::OFS_CMD:    rd_mux = 32'h0000_0000;
            ccd_pkg::OFS_STATUS: rd_mux = {28'h0000000, state_q == ST_EXEC2,
                                           dog_expiry_flag_q, sleep_entered_flag_q,
                                           zero_flag_q};
            ccd_pkg::OFS_PC:     rd_mux = {17'h00000, pc_q};
            ccd_pkg::OFS_ACC:    rd_mux = {24'h000000, acc_q};
            ccd_pkg::OFS_LATCH:  rd_mux = {25'h0000000, upper_pc_latch_q};
            ccd_pkg::OFS_STACK:  rd_mux = {17'h00000, stack_q[sp_q]};
            ccd_pkg::OFS_TIMER:  rd_mux = {16'h0000, timer_pre_q, supervisory_timer_q};
            default:             hit    = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc_cyc;
         pslverr_q <= acc_cyc && !hit;
         prdata_q  <= (acc_cyc && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_call_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == ST_EXEC2 |=> state_q == ST_IDLE) else $error("call not two cycles");
   chk_call_pc_load: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == ST_EXEC2 && !call_acc_q |=> pc_q == {$past(upper_pc_latch_q[6:3]),
      $past(k_q)}) else $error("immediate call target wrong");
   chk_acc_call_load: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == ST_EXEC2 && call_acc_q |=> pc_q == {$past(upper_pc_latch_q),
      $past(acc_q)}) else $error("accumulator call target wrong");
   chk_acc_call_len: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_CALL_ACC) |=> state_q == ST_EXEC2 ##1
      state_q == ST_IDLE) else $error("accumulator call length wrong");
   chk_timer_clear: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_TIMER_CLR) |=> supervisory_timer_q == 8'h00
      && dog_expiry_flag_q && sleep_entered_flag_q) else $error("timer clear failed");
   chk_acc_zero: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_ACC_ZERO) |=> acc_q == 8'h00 && zero_flag_q)
      else $error("accumulator zero failed");
   chk_call_flags: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == ST_EXEC2 |-> $stable(zero_flag_q) && $stable(dog_expiry_flag_q)
      && $stable(sleep_entered_flag_q)) else $error("call changed a flag");
   chk_dec_zero: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_REG_DEC) |=> zero_flag_q ==
      ($past(fr_rdata) == 8'h01)) else $error("decrement null flag wrong");
   chk_push_slot: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_CALL_IMM) |=> sp_q == $past(sp_q) + 4'h1
      && stack_q[sp_q] == $past(pc_inc)) else $error("push slot wrong");
   cov_call_imm: cover property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_CALL_IMM));
   cov_dec_to_zero: cover property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op_raw == 3'(ccd_pkg::CCD_OP_REG_DEC) && fr_rdata == 8'h01);
   cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr_q);
endmodule // ccd_exec

// File: hw/ccd_file_ram.sv
// file register storage, 128 bytes of flip-flops
`timescale 1ns/10ps
module ccd_file_ram #(
   parameter int AW = 7
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output      logic [7:0]    rdata
);
   logic [7:0] mem_q [2**AW];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2**AW; i++) mem_q[i] <= 8'h00;
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   assign rdata = mem_q[raddr];
endmodule // ccd_file_ram

// File: pkg/ccd_pkg.sv
// constants and types for the call/clear/decrement execution block
package ccd_pkg;
   // ----------------------------------------------------------------
   // opcode selects
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CCD_OP_NONE,
      CCD_OP_CALL_IMM,
      CCD_OP_CALL_ACC,
      CCD_OP_TIMER_CLR,
      CCD_OP_REG_INV,
      CCD_OP_REG_ZERO,
      CCD_OP_REG_DEC,
      CCD_OP_ACC_ZERO
   } ccd_op_t;
   // ----------------------------------------------------------------
   // widths, counts and reset values
   // ----------------------------------------------------------------
   localparam int          PC_W         = 15;
   localparam int          STK_DEPTH    = 16;
   localparam int          STK_PTR_W    = 4;
   localparam int          CALL_CYCLES  = 2;
   localparam int          IMM_W        = 11;
   localparam int          FADDR_W      = 7;
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam logic [7:0]  TIMER_CLR_V  = 8'h00;
   localparam logic [14:0] PC_RST       = 15'h0000;
   // ----------------------------------------------------------------
   // register offsets (word aligned)
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFS_CMD      = 8'h00;
   localparam logic [7:0]  OFS_STATUS   = 8'h04;
   localparam logic [7:0]  OFS_PC       = 8'h08;
   localparam logic [7:0]  OFS_ACC      = 8'h0c;
   localparam logic [7:0]  OFS_LATCH    = 8'h10;
   localparam logic [7:0]  OFS_STACK    = 8'h14;
   localparam logic [7:0]  OFS_TIMER    = 8'h18;
   localparam logic [7:0]  OFS_FILE     = 8'h80;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          CMD_OP_LSB   = 0;
   localparam int          CMD_D_BIT    = 3;
   localparam int          CMD_F_LSB    = 4;
   localparam int          CMD_K_LSB    = 16;
   localparam int          ST_ZERO_BIT  = 0;
   localparam int          ST_SLEEP_BIT = 1;
   localparam int          ST_DOG_BIT   = 2;
   localparam int          ST_BUSY_BIT  = 3;
endpackage
